// ### core/ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses on the apb bus)
// ---------------------------------------------------------------
`define CCR_OFS_PWRPLL 12'h000
`define CCR_OFS_STATUS 12'h004

// ---------------------------------------------------------------
// power and pll control register fields
// ---------------------------------------------------------------
`define CCR_MULT_LSB 0
`define CCR_MULT_W 7
`define CCR_DIV_LSB 8
`define CCR_DIV_W 2
`define CCR_PINSEL_BIT 12

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define CCR_ST_RUN_BIT 0
`define CCR_ST_LOCK_BIT 1
`define CCR_ST_RATIO_LSB 2
`define CCR_ST_PLLSEL_BIT 4
`define CCR_ST_COUNT_LSB 16

// ---------------------------------------------------------------
// reset values and multipliers chosen by the ratio pins
// ---------------------------------------------------------------
`define CCR_MULT_RATIO_3 7'h03
`define CCR_MULT_RATIO_16 7'h10
`define CCR_MULT_RATIO_8 7'h08
`define CCR_MULT_RESET 7'h03
`define CCR_DIV_RESET 2'h0
`define CCR_PINSEL_RESET 1'b0

// ---------------------------------------------------------------
// timing: pll lock wait in reference clock cycles
// ---------------------------------------------------------------
`define CCR_LOCK_REF_CYCLES 4096
`define CCR_LOCK_CNT_W 13

`endif

// ### core/ccr_lock_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_lock_timer #(
  parameter int CNT_W = `CCR_LOCK_CNT_W,
  parameter int LOCK_CYCLES = `CCR_LOCK_REF_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic ref_edge,
  output logic busy,
  output logic done,
  output logic [CNT_W-1:0] count
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LOCK_CYCLES);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic busy_q;
  logic busy_d;

  // next count: restart on start, count reference edges while busy
  always_comb begin
    count_d = count_q;
    busy_d = busy_q;
    if (start) begin
      count_d = '0;
      busy_d = 1'b1;
    end else if (busy_q && ref_edge) begin
      count_d = count_q + CNT_W'(1);
      // stop at the last edge so the count stays readable
      if (count_d == LAST) begin
        busy_d = 1'b0;
      end
    end
  end

  // counter registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
      busy_q <= 1'b0;
    end else begin
      count_q <= count_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign done = (count_q == LAST);
  assign count = count_q;

endmodule // ccr_lock_timer

`default_nettype wire

// ### core/ccr_pkg.sv
package ccr_pkg;

  // start-up sequencer states, one-hot
  typedef enum logic [2:0] {
    CCR_ST_CAPTURE = 3'b001,
    CCR_ST_LOCK = 3'b010,
    CCR_ST_RUN = 3'b100
  } ccr_state_type;

  // encoding of the two ratio-select pins
  typedef enum logic [1:0] {
    CCR_RATIO_3 = 2'b00,
    CCR_RATIO_16 = 2'b01,
    CCR_RATIO_8 = 2'b10,
    CCR_RATIO_RSVD = 2'b11
  } ccr_ratio_type;

endpackage

// ### core/ccr_top.sv
// Operation
// [R1] The core clock comes from the pll or straight from the reference clock as the ratio pins select.
// [R2] The ratio pins are sampled on leaving reset and fix the start-up core-to-reference ratio.
// [R3] Pin code 00 gives 3:1, 01 gives 16:1, 10 gives 8:1, and 11 is reserved.
// [R4] After the core leaves reset software may rewrite the pll multiplier and divider at any time.
// [R5] Bit 12 of the power and pll control register picks reset-out or pll clock on the shared pin, reset-out by default.
// [R6] In reset-out function the shared pin carries the internal core reset.
// [R7] After reset release the block waits 4096 reference cycles for lock, then the core starts at the reset vector.
// [R8] The reset source holds the active-low reset low at power-up, and reset returns all logic to a known state.
// [R9] The reference clock runs without stopping at a stable frequency no lower than the minimum.
// [R10] Core reset and the reset-out pin stay asserted through the lock wait and are released together.
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_top #(
  parameter int ADDR_W = 12,
  parameter int LOCK_CYCLES = `CCR_LOCK_REF_CYCLES,
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reference_clock_in,
  input wire logic [1:0] core_ratio_select_pins,
  input wire logic pll_clock_in,
  output logic core_reset_n,
  output logic core_clock_from_pll,
  output logic [`CCR_MULT_W-1:0] pll_multiplier,
  output logic [`CCR_DIV_W-1:0] pll_divider,
  output logic core_fetch_start,
  output logic [31:0] core_fetch_address,
  output logic reset_or_clock_out_pin
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------

  // multiplier implied by the ratio pins; reserved falls back to 3:1
  function automatic logic [`CCR_MULT_W-1:0] ratio_mult(
    input logic [1:0] code
  );
    case (code)
      ccr_pkg::CCR_RATIO_3: ratio_mult = `CCR_MULT_RATIO_3;
      ccr_pkg::CCR_RATIO_16: ratio_mult = `CCR_MULT_RATIO_16;
      ccr_pkg::CCR_RATIO_8: ratio_mult = `CCR_MULT_RATIO_8;
      default: ratio_mult = `CCR_MULT_RESET;
    endcase
  endfunction

  // merge write data into an old word under the byte strobes
  function automatic logic [31:0] strobe_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    strobe_merge = res;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ccr_pkg::ccr_state_type state_q;
  ccr_pkg::ccr_state_type state_d;
  logic ref_prev_q;
  logic ref_edge;
  logic [1:0] ratio_q;
  logic [1:0] ratio_d;
  logic pll_sel_q;
  logic pll_sel_d;
  logic [`CCR_MULT_W-1:0] mult_q;
  logic [`CCR_MULT_W-1:0] mult_d;
  logic [`CCR_DIV_W-1:0] div_q;
  logic [`CCR_DIV_W-1:0] div_d;
  logic pinsel_q;
  logic pinsel_d;
  logic core_rst_n_q;
  logic core_rst_n_d;
  logic fetch_q;
  logic fetch_d;
  logic pin_q;
  logic pin_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic [`CCR_LOCK_CNT_W-1:0] timer_count;
  logic setup_phase;
  logic access_phase;
  logic hit_pwrpll;
  logic hit_status;
  logic wr_refused;
  logic [31:0] pwrpll_word;
  logic [31:0] status_word;
  logic [31:0] pwrpll_new;

  // ---------------------------------------------------------------
  // reference clock edge detect
  // ---------------------------------------------------------------

  // reference clock is taken as synchronous to pclk; relies on it
  // running steadily, a stopped reference would stall the lock wait
  // [R9] steady reference assumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= reference_clock_in;
    end
  end

  assign ref_edge = reference_clock_in && !ref_prev_q;

  // ---------------------------------------------------------------
  // lock wait counter
  // ---------------------------------------------------------------
  ccr_lock_timer #(
    .CNT_W(`CCR_LOCK_CNT_W),
    .LOCK_CYCLES(LOCK_CYCLES)
  ) u_lock_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(timer_start),
    .ref_edge(ref_edge),
    .busy(timer_busy),
    .done(timer_done),
    .count(timer_count)
  );

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------

  // zero wait states: every access completes in its access cycle
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_pwrpll = (paddr == `CCR_OFS_PWRPLL);
  assign hit_status = (paddr == `CCR_OFS_STATUS);

  // pll settings only move once the core runs; status is read-only
  // [R4] writes after core start
  assign wr_refused = pwrite && (hit_status ||
                      (hit_pwrpll && state_q != ccr_pkg::CCR_ST_RUN));

  assign pready = 1'b1;
  assign pslverr = access_phase && ((!hit_pwrpll && !hit_status) ||
                   wr_refused);
  assign prdata = rdata_q;

  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------

  // power and pll control register as software sees it
  always_comb begin
    pwrpll_word = 32'h0000_0000;
    pwrpll_word[`CCR_MULT_LSB +: `CCR_MULT_W] = mult_q;
    pwrpll_word[`CCR_DIV_LSB +: `CCR_DIV_W] = div_q;
    pwrpll_word[`CCR_PINSEL_BIT] = pinsel_q;
  end

  // status shows sequencer state, captured pins and lock progress
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CCR_ST_RUN_BIT] = (state_q == ccr_pkg::CCR_ST_RUN);
    status_word[`CCR_ST_LOCK_BIT] = timer_busy;
    status_word[`CCR_ST_RATIO_LSB +: 2] = ratio_q;
    status_word[`CCR_ST_PLLSEL_BIT] = pll_sel_q;
    status_word[`CCR_ST_COUNT_LSB +: `CCR_LOCK_CNT_W] = timer_count;
  end

  assign pwrpll_new = strobe_merge(pwrpll_word, pwdata, pstrb);

  // ---------------------------------------------------------------
  // start-up sequencer and control state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ratio_d = ratio_q;
    pll_sel_d = pll_sel_q;
    mult_d = mult_q;
    div_d = div_q;
    pinsel_d = pinsel_q;
    fetch_d = 1'b0;
    timer_start = 1'b0;
    case (state_q)
      ccr_pkg::CCR_ST_CAPTURE: begin
        // pins are caught by a clocked step just after release,
        // never loaded through the asynchronous reset
        // [R2] sample ratio pins
        ratio_d = core_ratio_select_pins;
        // [R3] decode pin ratio
        mult_d = ratio_mult(core_ratio_select_pins);
        // [R1] pll or bypass
        pll_sel_d = (core_ratio_select_pins != ccr_pkg::CCR_RATIO_RSVD);
        timer_start = 1'b1;
        state_d = ccr_pkg::CCR_ST_LOCK;
      end
      ccr_pkg::CCR_ST_LOCK: begin
        // [R7] wait for lock count
        if (timer_done) begin
          fetch_d = 1'b1;
          state_d = ccr_pkg::CCR_ST_RUN;
        end
      end
      ccr_pkg::CCR_ST_RUN: begin
        // [R4] reprogram multiplier and divider
        if (access_phase && pwrite && hit_pwrpll) begin
          mult_d = pwrpll_new[`CCR_MULT_LSB +: `CCR_MULT_W];
          div_d = pwrpll_new[`CCR_DIV_LSB +: `CCR_DIV_W];
          // [R5] shared pin function select
          pinsel_d = pwrpll_new[`CCR_PINSEL_BIT];
        end
      end
      default: begin
        state_d = ccr_pkg::CCR_ST_CAPTURE;
      end
    endcase
  end

  // core reset follows the sequencer; in reset-out function the shared pin
  // mirrors it in the same edge so the two can never drift apart
  always_comb begin
    // [R10] release with lock end
    core_rst_n_d = (state_d == ccr_pkg::CCR_ST_RUN);
    // [R6] pin carries core reset
    pin_d = pinsel_d ? pll_clock_in : core_rst_n_d;
  end

  // read data is fetched in the setup cycle, held for the access
  always_comb begin
    rdata_d = rdata_q;
    if (setup_phase && !pwrite) begin
      if (hit_pwrpll) begin
        rdata_d = pwrpll_word;
      end else if (hit_status) begin
        rdata_d = status_word;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------

  // every register returns to a constant while reset is low
  // [R8] known state in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ccr_pkg::CCR_ST_CAPTURE;
      ratio_q <= 2'h0;
      pll_sel_q <= 1'b0;
      mult_q <= `CCR_MULT_RESET;
      div_q <= `CCR_DIV_RESET;
      pinsel_q <= `CCR_PINSEL_RESET;
      core_rst_n_q <= 1'b0;
      fetch_q <= 1'b0;
      pin_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      ratio_q <= ratio_d;
      pll_sel_q <= pll_sel_d;
      mult_q <= mult_d;
      div_q <= div_d;
      pinsel_q <= pinsel_d;
      core_rst_n_q <= core_rst_n_d;
      fetch_q <= fetch_d;
      pin_q <= pin_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // the pll clock on the pin is resampled by pclk, so it is only
  // faithful for pll rates well below half of pclk
  assign reset_or_clock_out_pin = pin_q;
  assign core_reset_n = core_rst_n_q;
  assign core_clock_from_pll = pll_sel_q;
  assign pll_multiplier = mult_q;
  assign pll_divider = div_q;
  assign core_fetch_start = fetch_q;
  assign core_fetch_address = RESET_VECTOR;

endmodule // ccr_top

`default_nettype wire

// ### tb/ccr_clk_src.sv
`timescale 1ns/1ps
`default_nettype none

module ccr_clk_src #(
  parameter int HALF = 2
) (
  input wire logic pclk,
  output logic ref_clk,
  output logic pll_clk
);
  logic [7:0] cnt_q;

  // known levels at time zero, the bench never ties them
  initial begin
    cnt_q = 8'h00;
    ref_clk = 1'b0;
    pll_clk = 1'b0;
  end

  // reference never stops
  // changes only after a rising edge, so the block sees clean levels
  always @(posedge pclk) begin
    cnt_q <= (cnt_q == 8'(HALF - 1)) ? 8'h00 : cnt_q + 8'h01;
    if (cnt_q == 8'(HALF - 1)) ref_clk <= ~ref_clk;
    pll_clk <= ~pll_clk; // fastest pattern shows any extra delay
  end
endmodule // ccr_clk_src

`default_nettype wire

// ### tb/ccr_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_properties #(
  parameter int ADDR_W = 12,
  parameter int LOCK_CYCLES = 8,
  parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic reference_clock_in,
  input wire logic [1:0] core_ratio_select_pins,
  input wire logic pll_clock_in,
  input wire logic core_reset_n,
  input wire logic core_clock_from_pll,
  input wire logic [6:0] pll_multiplier,
  input wire logic [1:0] pll_divider,
  input wire logic core_fetch_start,
  input wire logic [31:0] core_fetch_address,
  input wire logic reset_or_clock_out_pin
);
  logic first_q, first_d, ref_q, ref_d, sel_q, sel_d, wr;
  logic [1:0] pins_q, pins_d;
  logic [15:0] edges_q, edges_d;
  logic [6:0] exp_mult;
  logic [8:0] wfield;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // accepted control register write and the fields it carries
  assign wr = psel && penable && pwrite && paddr == '0 && !pslverr;
  assign wfield = {pwdata[9:8], pwdata[6:0]};
  assign exp_mult = pins_q == 2'h1 ? `CCR_MULT_RATIO_16 :
                    pins_q == 2'h2 ? `CCR_MULT_RATIO_8 : `CCR_MULT_RATIO_3;

  // captured pins, reference edges seen during the wait, pin select
  always_comb begin
    first_d = 1'b1;
    pins_d = first_q ? pins_q : core_ratio_select_pins;
    ref_d = reference_clock_in;
    edges_d = edges_q + 16'(reference_clock_in && !ref_q && !core_reset_n);
    sel_d = (wr && pstrb[1]) ? pwdata[12] : sel_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b0;
      pins_q <= 2'h0;
      ref_q <= 1'b0;
      edges_q <= 16'h0000;
      sel_q <= 1'b0;
    end else begin
      first_q <= first_d;
      pins_q <= pins_d;
      ref_q <= ref_d;
      edges_q <= edges_d;
      sel_q <= sel_d;
    end
  end

  a_ratio_mult: assert property (
    first_q && !core_reset_n |-> pll_multiplier == exp_mult &&
    pll_divider == `CCR_DIV_RESET) else $error("start-up multiplier wrong");
  a_core_source: assert property (
    first_q && !core_reset_n |-> core_clock_from_pll == (pins_q != 2'h3))
    else $error("core clock source wrong");
  a_hold_pin: assert property (
    !core_reset_n |-> !reset_or_clock_out_pin)
    else $error("reset-out released during wait");
  a_release_pair: assert property (
    $rose(core_reset_n) |-> reset_or_clock_out_pin && core_fetch_start)
    else $error("release not together");
  a_fetch_pulse: assert property (
    core_fetch_start |-> $rose(core_reset_n) ##1 !core_fetch_start)
    else $error("fetch pulse wrong");
  a_fetch_vector: assert property (
    core_fetch_start |-> core_fetch_address == RESET_VECTOR)
    else $error("fetch address wrong");
  a_lock_min: assert property (
    $rose(core_reset_n) |-> edges_q >= LOCK_CYCLES)
    else $error("lock wait too short");
  a_lock_max: assert property (
    !core_reset_n |-> edges_q <= LOCK_CYCLES + 2)
    else $error("lock wait too long");
  a_write_gate: assert property (
    psel && penable && pwrite && paddr == '0 |-> pslverr == !core_reset_n)
    else $error("control write gating wrong");
  a_write_fields: assert property (
    wr && pstrb == 4'hf |=> {pll_divider, pll_multiplier} == $past(wfield))
    else $error("control write not applied");
  a_pin_clock: assert property (
    sel_q && $past(sel_q) |-> reset_or_clock_out_pin == $past(pll_clock_in))
    else $error("pin not carrying pll clock");
  a_pin_reset: assert property (
    !sel_q && !$past(sel_q) && core_reset_n |-> reset_or_clock_out_pin)
    else $error("pin not carrying core reset");

  c_release: cover property ($rose(core_reset_n));
  c_clock_out: cover property (sel_q && pll_clock_in);
  c_refused: cover property (psel && penable && pslverr);
endmodule // ccr_properties

bind ccr_top ccr_properties #(.ADDR_W(ADDR_W), .LOCK_CYCLES(LOCK_CYCLES),
  .RESET_VECTOR(RESET_VECTOR)) u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pslverr(pslverr),
  .reference_clock_in(reference_clock_in),
  .core_ratio_select_pins(core_ratio_select_pins),
  .pll_clock_in(pll_clock_in), .core_reset_n(core_reset_n),
  .core_clock_from_pll(core_clock_from_pll),
  .pll_multiplier(pll_multiplier), .pll_divider(pll_divider),
  .core_fetch_start(core_fetch_start),
  .core_fetch_address(core_fetch_address),
  .reset_or_clock_out_pin(reset_or_clock_out_pin));

`default_nettype wire

// ### tb/core_clock_reset_startup_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module core_clock_reset_startup_tb;
  localparam int LOCK = 8;
  localparam int REFP = 4;
  localparam logic [6:0] EM [4] = '{`CCR_MULT_RATIO_3, `CCR_MULT_RATIO_16,
    `CCR_MULT_RATIO_8, `CCR_MULT_RESET};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, fa;
  logic [3:0] pstrb = 4'h0;
  logic [1:0] pins = 2'h0, code, div;
  logic pready, pslverr, ref_clk, pll_clk, crst_n, from_pll, fetch, pin, err, p;
  logic [6:0] mult;
  time t0, lat;
  int mismatches = 0;
  int checks = 0;

  always #2 pclk = ~pclk;

  ccr_clk_src #(.HALF(REFP / 2)) u_src (.pclk(pclk), .ref_clk(ref_clk),
    .pll_clk(pll_clk));
  ccr_top #(.LOCK_CYCLES(LOCK)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reference_clock_in(ref_clk),
    .core_ratio_select_pins(pins), .pll_clock_in(pll_clk),
    .core_reset_n(crst_n), .core_clock_from_pll(from_pll),
    .pll_multiplier(mult), .pll_divider(div), .core_fetch_start(fetch),
    .core_fetch_address(fa), .reset_or_clock_out_pin(pin));

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; an idle edge after it keeps drivers single per step
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the watchdog ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, far beyond four start-ups and the run tests
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    results();
  end

  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      code = 2'(3 - i);
      @(posedge pclk);
      pins <= code;
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("reset_mult", 32'(`CCR_MULT_RESET), 32'(mult));
      chk("reset_outs", 32'h0, 32'({crst_n, pin, fetch, from_pll, div}));
      presetn <= 1'b1;
      t0 = $time;
      repeat (3) @(posedge pclk);
      pins <= ~code; // late change must be ignored
      xfer(1'b1, 12'h000, 32'h0000_0025, 4'hf);
      chk("early_write_err", 32'h1, 32'(err));
      chk("start_mult", 32'(EM[code]), 32'(mult));
      chk("core_source", 32'(code != 2'h3), 32'(from_pll));
      chk("pin_in_wait", 32'h0, 32'(pin));
      for (int c = 0; c < 400 && fetch !== 1'b1; c++) @(posedge pclk);
      lat = ($time - t0) / 4;
      chk("lock_wait", 32'h1, 32'(lat >= LOCK * REFP - REFP &&
          lat <= LOCK * REFP + 3 * REFP));
      chk("fetch_addr", 32'h0, fa);
      chk("released", 32'h3, 32'({crst_n, pin}));
      $display("startup test done for code %0d", code);
    end
    xfer(1'b1, 12'h000, 32'h0000_0225, 4'hf);
    chk("run_write_err", 32'h0, 32'(err));
    chk("mult_div", 32'h0000_0125, 32'({div, mult}));
    xfer(1'b0, 12'h000, 32'h0, 4'h0);
    chk("pwrpll_read", 32'h0000_0225, rd & 32'h0000_137f);
    xfer(1'b1, 12'h000, 32'h0000_1225, 4'hf);
    repeat (2) @(posedge pclk);
    for (int k = 0; k < 6; k++) begin
      p = pll_clk;
      @(posedge pclk);
      chk("pin_clock", 32'(p), 32'(pin));
    end
    xfer(1'b1, 12'h000, 32'h0000_0225, 4'h2);
    repeat (2) @(posedge pclk);
    chk("pin_reset", 32'h1, 32'(pin));
    xfer(1'b0, 12'h008, 32'h0, 4'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    xfer(1'b1, 12'h004, 32'hffff_ffff, 4'hf);
    chk("status_write_err", 32'h1, 32'(err));
    xfer(1'b0, 12'h004, 32'h0, 4'h0);
    chk("status", 32'h0000_0011, rd & 32'h0000_001f);
    $display("run test done");
    results();
  end
endmodule // core_clock_reset_startup_tb

`default_nettype wire
